// File: uidma_pkg.sv
// Constants and carrier types for the channel interrupt and DMA signalling block
package uidma_pkg;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_MASK = 3'h1;
  localparam logic [2:0] ADDR_FIFO = 3'h2;
  localparam logic [2:0] ADDR_LINE_CTRL = 3'h3;
  localparam logic [2:0] ADDR_LINE_STAT = 3'h5;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
  localparam logic [1:0] TRIG_SEL_RESET = 2'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int MASK_RX_BIT = 0;
  localparam int MASK_THR_BIT = 1;
  localparam int MASK_LINE_BIT = 2;
  localparam int MASK_MODEM_BIT = 3;
  localparam int FIFO_EN_BIT = 0;
  localparam int RX_RESET_BIT = 1;
  localparam int TX_RESET_BIT = 2;
  localparam int DMA_MODE_BIT = 3;
  localparam int TRIG_LSB = 6;
  localparam int TRIG_MSB = 7;
  localparam int DLAB_BIT = 7;

  // ************************************************************
  // FIFO depth and receive trigger levels
  // ************************************************************
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] TRIG_LEVEL_0 = 5'h01;
  localparam logic [4:0] TRIG_LEVEL_1 = 5'h04;
  localparam logic [4:0] TRIG_LEVEL_2 = 5'h08;
  localparam logic [4:0] TRIG_LEVEL_3 = 5'h0e;

  // ************************************************************
  // Interrupt identification codes, bits 3:0
  // ************************************************************
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_LINE = 4'h6;
  localparam logic [3:0] ID_RX = 4'h4;
  localparam logic [3:0] ID_TIMEOUT = 4'hc;
  localparam logic [3:0] ID_THR = 4'h2;
  localparam logic [3:0] ID_MODEM = 4'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic
  {
    UIDMA_MODE_16 = 1'b0,
    UIDMA_MODE_68 = 1'b1
  } uidma_bus_mode_t;

  typedef struct packed
  {
    logic sel;
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uidma_bus_t;

  typedef struct packed
  {
    logic [4:0] rx_count;
    logic [4:0] tx_count;
    logic tx_shift_empty;
    logic [3:0] rx_errors;
    logic fifo_error;
    logic rx_timeout;
    logic modem_change;
  } uidma_engine_t;

endpackage : uidma_pkg

// File: uidma_signal.sv
// Interrupt mask, identification, line status and DMA request logic of one channel
`timescale 1ns/1ps
module uidma_signal
(
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire uidma_pkg::uidma_bus_t BUS_I,
  input wire uidma_pkg::uidma_bus_mode_t BUS_MODE_I,
  input wire uidma_pkg::uidma_engine_t ENGINE_I,
  output logic [7:0] RDATA_O,
  output logic RVALID_O,
  output logic TX_FIFO_RESET_O,
  output logic RX_FIFO_RESET_O,
  output logic LINE_STAT_READ_O,
  output logic TX_DMA_REQUEST_N_O,
  output logic RX_DMA_REQUEST_N_O,
  output logic CHANNEL_IRQ_OUT_O,
  output logic SHARED_IRQ_N_O,
  output logic SHARED_IRQ_OE_O
);

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    logic [4:0] lvl;
    lvl = uidma_pkg::TRIG_LEVEL_0;
    unique case (sel)
      2'h0: lvl = uidma_pkg::TRIG_LEVEL_0;
      2'h1: lvl = uidma_pkg::TRIG_LEVEL_1;
      2'h2: lvl = uidma_pkg::TRIG_LEVEL_2;
      2'h3: lvl = uidma_pkg::TRIG_LEVEL_3;
    endcase
    return lvl;
  endfunction : trig_level

  function automatic logic bus_hit(input uidma_pkg::uidma_bus_t bus, input logic [2:0] a);
    return bus.sel && (bus.addr == a);
  endfunction : bus_hit

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [3:0] interrupt_mask_reg;
  logic [7:0] line_control_reg;
  logic fifo_enable;
  logic dma_mode;
  logic [1:0] trig_sel;
  logic thr_pend;
  logic tx_empty_q;
  logic rx_dma_hold;
  logic dlab;
  logic wr_mask;
  logic wr_fifo;
  logic wr_line_ctrl;
  logic wr_hold;
  logic rd_ident;
  logic rd_line_stat;
  logic rd_any;
  logic tx_empty;
  logic rx_at_trig;
  logic rx_empty;
  logic line_pend;
  logic rx_pend;
  logic timeout_pend;
  logic modem_pend;
  logic any_pend;
  logic [3:0] ident_code;
  logic [7:0] interrupt_ident_reg;
  logic [7:0] line_status_reg;
  logic [7:0] next_rdata;
  logic next_thr_pend;

  // ************************************************************
  // Bus decode
  // ************************************************************
  assign dlab = line_control_reg[uidma_pkg::DLAB_BIT];
  // Mask and holding registers are hidden behind the divisor latch
  assign wr_mask = BUS_I.wr && bus_hit(BUS_I, uidma_pkg::ADDR_MASK) && !dlab;
  assign wr_hold = BUS_I.wr && bus_hit(BUS_I, uidma_pkg::ADDR_HOLD) && !dlab;
  assign wr_fifo = BUS_I.wr && bus_hit(BUS_I, uidma_pkg::ADDR_FIFO);
  assign wr_line_ctrl = BUS_I.wr && bus_hit(BUS_I, uidma_pkg::ADDR_LINE_CTRL);
  assign rd_any = BUS_I.rd && BUS_I.sel;
  assign rd_ident = BUS_I.rd && bus_hit(BUS_I, uidma_pkg::ADDR_FIFO);
  assign rd_line_stat = BUS_I.rd && bus_hit(BUS_I, uidma_pkg::ADDR_LINE_STAT);

  // ************************************************************
  // Control registers
  // ************************************************************
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESETN_I)
    begin
      interrupt_mask_reg <= uidma_pkg::MASK_RESET;
    end
    else if (wr_mask)
    begin
      // Upper bits are not stored and read as zero
      interrupt_mask_reg <= BUS_I.wdata[3:0];
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESETN_I)
    begin
      line_control_reg <= uidma_pkg::LINE_CTRL_RESET;
    end
    else if (wr_line_ctrl)
    begin
      line_control_reg <= BUS_I.wdata;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESETN_I)
    begin
      fifo_enable <= 1'b0;
      dma_mode <= 1'b0;
      trig_sel <= uidma_pkg::TRIG_SEL_RESET;
    end
    else if (wr_fifo)
    begin
      fifo_enable <= BUS_I.wdata[uidma_pkg::FIFO_EN_BIT];
      dma_mode <= BUS_I.wdata[uidma_pkg::DMA_MODE_BIT];
      trig_sel <= BUS_I.wdata[uidma_pkg::TRIG_MSB:uidma_pkg::TRIG_LSB];
    end
  end

  // FIFO reset bits are self-clearing, so they leave as one-cycle pulses
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESETN_I)
    begin
      TX_FIFO_RESET_O <= 1'b0;
      RX_FIFO_RESET_O <= 1'b0;
      LINE_STAT_READ_O <= 1'b0;
    end
    else
    begin
      TX_FIFO_RESET_O <= wr_fifo && BUS_I.wdata[uidma_pkg::TX_RESET_BIT];
      RX_FIFO_RESET_O <= wr_fifo && BUS_I.wdata[uidma_pkg::RX_RESET_BIT];
      LINE_STAT_READ_O <= rd_line_stat;
    end
  end

  // ************************************************************
  // FIFO state
  // ************************************************************
  assign tx_empty = (ENGINE_I.tx_count == 5'h00);
  assign rx_empty = (ENGINE_I.rx_count == 5'h00);
  // Without FIFOs one held character counts as reaching the level
  assign rx_at_trig = fifo_enable ? (ENGINE_I.rx_count >= trig_level(trig_sel)) : !rx_empty;

  // ************************************************************
  // Line status
  // ************************************************************
  always_comb
  begin
    line_status_reg = 8'h00;
    line_status_reg[0] = !rx_empty;
    line_status_reg[4:1] = ENGINE_I.rx_errors;
    line_status_reg[5] = tx_empty;
    line_status_reg[6] = tx_empty && ENGINE_I.tx_shift_empty;
    // FIFO error summary has no meaning with FIFOs off
    line_status_reg[7] = fifo_enable && ENGINE_I.fifo_error;
  end

  // ************************************************************
  // Interrupt sources
  // ************************************************************
  // With every mask bit clear no source is identified, which leaves the
  // line status bits for polling on their own
  assign line_pend = interrupt_mask_reg[uidma_pkg::MASK_LINE_BIT]
    && (ENGINE_I.rx_errors != 4'h0);
  assign rx_pend = interrupt_mask_reg[uidma_pkg::MASK_RX_BIT] && rx_at_trig;
  assign timeout_pend = interrupt_mask_reg[uidma_pkg::MASK_RX_BIT] && fifo_enable
    && ENGINE_I.rx_timeout;
  assign modem_pend = interrupt_mask_reg[uidma_pkg::MASK_MODEM_BIT]
    && ENGINE_I.modem_change;

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESETN_I)
    begin
      tx_empty_q <= 1'b1;
    end
    else
    begin
      tx_empty_q <= tx_empty;
    end
  end

  // Holding-empty event is sticky until identified or refilled; a new
  // empty edge in the clearing cycle wins
  always_comb
  begin
    next_thr_pend = thr_pend;
    if (wr_hold || (rd_ident && (ident_code == uidma_pkg::ID_THR)))
    begin
      next_thr_pend = 1'b0;
    end
    if ((tx_empty && !tx_empty_q)
      || (wr_mask && BUS_I.wdata[uidma_pkg::MASK_THR_BIT]
      && !interrupt_mask_reg[uidma_pkg::MASK_THR_BIT] && tx_empty))
    begin
      next_thr_pend = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESETN_I)
    begin
      thr_pend <= 1'b0;
    end
    else
    begin
      thr_pend <= next_thr_pend;
    end
  end

  // ************************************************************
  // Identification, highest priority first
  // ************************************************************
  always_comb
  begin
    ident_code = uidma_pkg::ID_NONE;
    if (line_pend)
    begin
      ident_code = uidma_pkg::ID_LINE;
    end
    else if (rx_pend)
    begin
      ident_code = uidma_pkg::ID_RX;
    end
    else if (timeout_pend)
    begin
      ident_code = uidma_pkg::ID_TIMEOUT;
    end
    else if (thr_pend && interrupt_mask_reg[uidma_pkg::MASK_THR_BIT])
    begin
      ident_code = uidma_pkg::ID_THR;
    end
    else if (modem_pend)
    begin
      ident_code = uidma_pkg::ID_MODEM;
    end
  end

  assign any_pend = (ident_code != uidma_pkg::ID_NONE);
  assign interrupt_ident_reg = {fifo_enable, fifo_enable, 2'h0, ident_code};

  // ************************************************************
  // Read data
  // ************************************************************
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (BUS_I.addr)
      uidma_pkg::ADDR_MASK: next_rdata = dlab ? 8'h00 : {4'h0, interrupt_mask_reg};
      uidma_pkg::ADDR_FIFO: next_rdata = interrupt_ident_reg;
      uidma_pkg::ADDR_LINE_CTRL: next_rdata = line_control_reg;
      uidma_pkg::ADDR_LINE_STAT: next_rdata = line_status_reg;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESETN_I)
    begin
      RDATA_O <= uidma_pkg::RDATA_RESET;
      RVALID_O <= 1'b0;
    end
    else
    begin
      RVALID_O <= rd_any;
      if (rd_any)
      begin
        RDATA_O <= next_rdata;
      end
    end
  end

  // ************************************************************
  // Interrupt outputs
  // ************************************************************
  // Registered so the pins never glitch while sources change together
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESETN_I)
    begin
      CHANNEL_IRQ_OUT_O <= 1'b0;
      SHARED_IRQ_OE_O <= 1'b0;
    end
    else
    begin
      CHANNEL_IRQ_OUT_O <= any_pend && (BUS_MODE_I == uidma_pkg::UIDMA_MODE_16);
      SHARED_IRQ_OE_O <= any_pend && (BUS_MODE_I == uidma_pkg::UIDMA_MODE_68);
    end
  end

  // Open-drain request only ever pulls low
  assign SHARED_IRQ_N_O = 1'b0;

  // ************************************************************
  // DMA requests, active low
  // ************************************************************
  // Block-mode receive request latches at the level or a time-out and
  // lets go only when drained; the set wins over the empty release
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESETN_I)
    begin
      rx_dma_hold <= 1'b0;
    end
    else if (rx_at_trig || ENGINE_I.rx_timeout)
    begin
      rx_dma_hold <= 1'b1;
    end
    else if (rx_empty)
    begin
      rx_dma_hold <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RESETN_I)
    begin
      TX_DMA_REQUEST_N_O <= 1'b1;
      RX_DMA_REQUEST_N_O <= 1'b1;
    end
    else if (fifo_enable && dma_mode)
    begin
      TX_DMA_REQUEST_N_O <= !(ENGINE_I.tx_count < uidma_pkg::FIFO_DEPTH);
      RX_DMA_REQUEST_N_O <= !(rx_dma_hold || rx_at_trig || ENGINE_I.rx_timeout);
    end
    else
    begin
      TX_DMA_REQUEST_N_O <= !tx_empty;
      RX_DMA_REQUEST_N_O <= rx_empty;
    end
  end

endmodule : uidma_signal

// File: uidma_engine_model.sv
// Behavioural serial engine model that feeds fill levels and status to the block
`timescale 1ns/1ps
module uidma_engine_model
(
  input wire logic clk_i,
  input wire logic rx_put_i,
  input wire logic rx_get_i,
  input wire logic tx_put_i,
  input wire logic tx_get_i,
  input wire logic rx_clr_i,
  input wire logic tx_clr_i,
  input wire logic [7:0] misc_i,
  output uidma_pkg::uidma_engine_t eng_o
);
  // ************************************************************
  // Fill levels
  // ************************************************************
  logic [4:0] rxc = 5'h00;
  logic [4:0] txc = 5'h00;

  // Receive side keeps filling past the trigger until full
  always @(posedge clk_i)
  begin
    if (rx_clr_i)
      rxc <= 5'h00;
    else if (rx_put_i && rxc != 5'h10)
      rxc <= rxc + 5'h01;
    else if (rx_get_i && rxc != 5'h00)
      rxc <= rxc - 5'h01;
  end

  always @(posedge clk_i)
  begin
    if (tx_clr_i)
      txc <= 5'h00;
    else if (tx_put_i && txc != 5'h10)
      txc <= txc + 5'h01;
    else if (tx_get_i && txc != 5'h00)
      txc <= txc - 5'h01;
  end

  assign eng_o = {rxc, txc, misc_i};
endmodule : uidma_engine_model

// File: uidma_signal_props.sv
// Port-level assertions for the channel signalling block
`timescale 1ns/1ps
module uidma_signal_props
(
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire uidma_pkg::uidma_bus_t BUS_I,
  input wire uidma_pkg::uidma_bus_mode_t BUS_MODE_I,
  input wire uidma_pkg::uidma_engine_t ENGINE_I,
  input wire logic [7:0] RDATA_O,
  input wire logic RVALID_O,
  input wire logic TX_FIFO_RESET_O,
  input wire logic RX_FIFO_RESET_O,
  input wire logic LINE_STAT_READ_O,
  input wire logic TX_DMA_REQUEST_N_O,
  input wire logic RX_DMA_REQUEST_N_O,
  input wire logic CHANNEL_IRQ_OUT_O,
  input wire logic SHARED_IRQ_N_O,
  input wire logic SHARED_IRQ_OE_O
);
  // ************************************************************
  // Assertions
  // ************************************************************
  logic rd_go;
  logic wr_fifo;
  assign rd_go = BUS_I.sel && BUS_I.rd;
  assign wr_fifo = BUS_I.sel && BUS_I.wr && BUS_I.addr == uidma_pkg::ADDR_FIFO;
  default clocking ck @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  chk_status_read: assert property (
    rd_go && BUS_I.addr == uidma_pkg::ADDR_LINE_STAT |=> RVALID_O && LINE_STAT_READ_O)
    else $error("status read not answered");
  chk_valid_cause: assert property (RVALID_O |-> $past(rd_go))
    else $error("read data without a read");
  chk_rdata_hold: assert property (!RVALID_O |-> $stable(RDATA_O))
    else $error("read data moved without a read");
  chk_tx_clear: assert property (
    wr_fifo && BUS_I.wdata[uidma_pkg::TX_RESET_BIT] |=> TX_FIFO_RESET_O)
    else $error("transmit clear pulse missing");
  chk_rx_clear: assert property (
    wr_fifo && BUS_I.wdata[uidma_pkg::RX_RESET_BIT] |=> RX_FIFO_RESET_O)
    else $error("receive clear pulse missing");
  chk_tx_space: assert property (
    !TX_DMA_REQUEST_N_O |-> $past(ENGINE_I.tx_count) < uidma_pkg::FIFO_DEPTH)
    else $error("transmit request while full");
  chk_rx_full: assert property (
    ENGINE_I.rx_count >= 5'h0e |=> !RX_DMA_REQUEST_N_O)
    else $error("receive request missing near full");
  chk_irq_mode16: assert property (
    $rose(CHANNEL_IRQ_OUT_O) |-> $past(BUS_MODE_I) == uidma_pkg::UIDMA_MODE_16)
    else $error("channel output used in shared mode");
  chk_oe_mode68: assert property (
    SHARED_IRQ_OE_O |-> $past(BUS_MODE_I) == uidma_pkg::UIDMA_MODE_68)
    else $error("shared request used in separate mode");
  chk_shared_low: assert property (SHARED_IRQ_N_O == 1'b0)
    else $error("shared request data not low");

  cover property (rd_go && BUS_I.addr == uidma_pkg::ADDR_LINE_STAT);
  cover property ($fell(RX_DMA_REQUEST_N_O));
  cover property ($rose(CHANNEL_IRQ_OUT_O));
  cover property ($rose(SHARED_IRQ_OE_O));
endmodule : uidma_signal_props

bind uidma_signal uidma_signal_props chk
(
  .REF_CLK_I(REF_CLK_I),
  .RESETN_I(RESETN_I),
  .BUS_I(BUS_I),
  .BUS_MODE_I(BUS_MODE_I),
  .ENGINE_I(ENGINE_I),
  .RDATA_O(RDATA_O),
  .RVALID_O(RVALID_O),
  .TX_FIFO_RESET_O(TX_FIFO_RESET_O),
  .RX_FIFO_RESET_O(RX_FIFO_RESET_O),
  .LINE_STAT_READ_O(LINE_STAT_READ_O),
  .TX_DMA_REQUEST_N_O(TX_DMA_REQUEST_N_O),
  .RX_DMA_REQUEST_N_O(RX_DMA_REQUEST_N_O),
  .CHANNEL_IRQ_OUT_O(CHANNEL_IRQ_OUT_O),
  .SHARED_IRQ_N_O(SHARED_IRQ_N_O),
  .SHARED_IRQ_OE_O(SHARED_IRQ_OE_O)
);

// File: testbench.sv
// Self-checking bench for the channel signalling block
`timescale 1ns/1ps
module testbench;
  // ************************************************************
  // Signals, clock and instances
  // ************************************************************
  logic REF_CLK_I = 1'b0;
  logic RESETN_I = 1'b0;
  uidma_pkg::uidma_bus_t BUS_I = '0;
  uidma_pkg::uidma_bus_mode_t BUS_MODE_I = uidma_pkg::UIDMA_MODE_16;
  uidma_pkg::uidma_engine_t ENGINE_I;
  logic [7:0] RDATA_O;
  logic RVALID_O;
  logic TX_FIFO_RESET_O;
  logic RX_FIFO_RESET_O;
  logic LINE_STAT_READ_O;
  logic TX_DMA_REQUEST_N_O;
  logic RX_DMA_REQUEST_N_O;
  logic CHANNEL_IRQ_OUT_O;
  logic SHARED_IRQ_N_O;
  logic SHARED_IRQ_OE_O;
  logic [3:0] step = 4'h0;
  logic [7:0] misc = 8'h80;
  logic [31:0] v;
  logic [3:0] err;
  int mismatches = 0;
  int num_checks = 0;
  int seed = 32'hd3c7;
  int rxc = 0;
  int txc = 0;

  always #10 REF_CLK_I = ~REF_CLK_I;

  uidma_signal dut
  (
    .REF_CLK_I(REF_CLK_I),
    .RESETN_I(RESETN_I),
    .BUS_I(BUS_I),
    .BUS_MODE_I(BUS_MODE_I),
    .ENGINE_I(ENGINE_I),
    .RDATA_O(RDATA_O),
    .RVALID_O(RVALID_O),
    .TX_FIFO_RESET_O(TX_FIFO_RESET_O),
    .RX_FIFO_RESET_O(RX_FIFO_RESET_O),
    .LINE_STAT_READ_O(LINE_STAT_READ_O),
    .TX_DMA_REQUEST_N_O(TX_DMA_REQUEST_N_O),
    .RX_DMA_REQUEST_N_O(RX_DMA_REQUEST_N_O),
    .CHANNEL_IRQ_OUT_O(CHANNEL_IRQ_OUT_O),
    .SHARED_IRQ_N_O(SHARED_IRQ_N_O),
    .SHARED_IRQ_OE_O(SHARED_IRQ_OE_O)
  );
  uidma_engine_model partner
  (
    .clk_i(REF_CLK_I),
    .rx_put_i(step[3]),
    .rx_get_i(step[2]),
    .tx_put_i(step[1]),
    .tx_get_i(step[0]),
    .rx_clr_i(RX_FIFO_RESET_O),
    .tx_clr_i(TX_FIFO_RESET_O),
    .misc_i(misc),
    .eng_o(ENGINE_I)
  );

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // Every input change lands 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK_I);
    #1;
  endtask : tick

  // An idle cycle follows every access, so back-to-back calls never
  // rewrite the bus twice in one time step
  task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d);
    BUS_I = '{1'b1, w, !w, a, d};
    tick(1);
    BUS_I = '0;
    tick(1);
  endtask : access

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp, input string name);
    access(1'b0, a, 8'h00);
    check(name, RDATA_O, exp);
  endtask : rdchk

  // Both clear bits set, so the model starts empty
  task automatic fifo_control_reg(input logic [1:0] sel, input logic dma);
    access(1'b1, uidma_pkg::ADDR_FIFO, {sel, 2'b00, dma, 3'b111});
    tick(1);
    rxc = 0;
    txc = 0;
  endtask : fifo_control_reg

  task automatic mv(input int r, input int t);
    while (r != 0 || t != 0)
    begin
      step = {r > 0, r < 0, t > 0, t < 0};
      tick(1);
      rxc = rxc + (step[3] && rxc < 16) - (step[2] && rxc > 0);
      txc = txc + (step[1] && txc < 16) - (step[0] && txc > 0);
      r = r - step[3] + step[2];
      t = t - step[1] + step[0];
    end
    step = 4'h0;
  endtask : mv

  function automatic logic [7:0] lsr_exp(input logic fifo_on);
    return {fifo_on & misc[2], misc[7] && txc == 0, txc == 0, misc[6:3], rxc != 0};
  endfunction : lsr_exp

  function automatic int trig(input int s);
    return s == 0 ? 1 : s == 1 ? 4 : s == 2 ? 8 : 14;
  endfunction : trig

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial
  begin
    tick(8);
    check("reset_pins", {TX_DMA_REQUEST_N_O, RX_DMA_REQUEST_N_O, CHANNEL_IRQ_OUT_O,
      SHARED_IRQ_OE_O}, 8'h0c);
    RESETN_I = 1'b1;
    rdchk(uidma_pkg::ADDR_MASK, 8'h00, "mask_reset");
    rdchk(uidma_pkg::ADDR_LINE_STAT, 8'h60, "status_reset");
    access(1'b1, uidma_pkg::ADDR_LINE_CTRL, 8'h80);
    access(1'b1, uidma_pkg::ADDR_MASK, 8'h0f);
    access(1'b1, uidma_pkg::ADDR_LINE_CTRL, 8'h00);
    // Read back with the latch off, so a write that slipped through shows
    rdchk(uidma_pkg::ADDR_MASK, 8'h00, "mask_latched");
    rdchk(3'h7, 8'h00, "unmapped");
    for (int k = 0; k < 3; k++)
    begin
      v = $random(seed);
      // Random bus mode, flipped on odd passes, so either interrupt pin can be exercised
      v[8] = v[8] ^ k[0];
      err = v[7:4] | 4'h1;
      BUS_MODE_I = uidma_pkg::uidma_bus_mode_t'(v[8]);
      misc = k == 0 ? 8'h80 : k == 1 ? {1'b1, err, 3'b000} : 8'h81;
      access(1'b1, uidma_pkg::ADDR_MASK, 8'h02 << k);
      tick(2);
      check("irq_on", {CHANNEL_IRQ_OUT_O, SHARED_IRQ_OE_O}, v[8] ? 8'h01 : 8'h02);
      check("shared_pin", SHARED_IRQ_N_O, 8'h00);
      rdchk(uidma_pkg::ADDR_FIFO, k == 0 ? 8'h02 : k == 1 ? 8'h06 : 8'h00, "ident");
      if (k == 1)
        rdchk(uidma_pkg::ADDR_LINE_STAT, lsr_exp(1'b0), "status_err");
      misc = 8'h80;
      tick(2);
      check("irq_off", {CHANNEL_IRQ_OUT_O, SHARED_IRQ_OE_O}, 8'h00);
      access(1'b1, uidma_pkg::ADDR_MASK, 8'h00);
    end
    BUS_MODE_I = uidma_pkg::UIDMA_MODE_16;
    for (int s = 0; s < 4; s++)
    begin
      fifo_control_reg(s[1:0], 1'b0);
      access(1'b1, uidma_pkg::ADDR_MASK, 8'h01);
      mv(trig(s) - 1, 0);
      tick(2);
      check("rx_irq_below", CHANNEL_IRQ_OUT_O, 8'h00);
      mv(1, 0);
      tick(2);
      check("rx_irq_at", CHANNEL_IRQ_OUT_O, 8'h01);
      check("dma0_pins", {TX_DMA_REQUEST_N_O, RX_DMA_REQUEST_N_O}, 8'h00);
      rdchk(uidma_pkg::ADDR_FIFO, 8'hc4, "ident_trig");
      mv(-1, 0);
      tick(2);
      check("rx_irq_below", CHANNEL_IRQ_OUT_O, 8'h00);
      rdchk(uidma_pkg::ADDR_FIFO, 8'hc1, "ident_idle");
      access(1'b1, uidma_pkg::ADDR_MASK, 8'h00);
    end
    fifo_control_reg(2'h2, 1'b1);
    mv(7, 16);
    tick(2);
    check("dma1_idle", {TX_DMA_REQUEST_N_O, RX_DMA_REQUEST_N_O}, 8'h03);
    mv(1, -1);
    tick(2);
    check("dma1_on", {TX_DMA_REQUEST_N_O, RX_DMA_REQUEST_N_O}, 8'h00);
    mv(10, 0);
    tick(1);
    mv(-15, 0);
    tick(2);
    check("dma1_hold", RX_DMA_REQUEST_N_O, 8'h00);
    mv(-1, 0);
    tick(3);
    check("dma1_free", RX_DMA_REQUEST_N_O, 8'h01);
    mv(2, 0);
    misc = 8'h82;
    tick(2);
    misc = 8'h80;
    tick(3);
    check("timeout_req", RX_DMA_REQUEST_N_O, 8'h00);
    mv(-2, 0);
    tick(3);
    check("timeout_free", RX_DMA_REQUEST_N_O, 8'h01);
    access(1'b1, uidma_pkg::ADDR_MASK, 8'h01);
    misc = 8'h82;
    tick(1);
    rdchk(uidma_pkg::ADDR_FIFO, 8'hcc, "ident_timeout");
    check("timeout_irq", CHANNEL_IRQ_OUT_O, 8'h01);
    misc = 8'h80;
    access(1'b1, uidma_pkg::ADDR_MASK, 8'h00);
    fifo_control_reg(2'h2, 1'b0);
    mv(0, 1);
    tick(2);
    check("dma0_tx_busy", TX_DMA_REQUEST_N_O, 8'h01);
    // The FIFO clear left the holding-empty event pending; a refill drops it
    access(1'b1, uidma_pkg::ADDR_MASK, 8'h02);
    tick(1);
    check("thr_edge", CHANNEL_IRQ_OUT_O, 8'h01);
    access(1'b1, uidma_pkg::ADDR_HOLD, 8'h55);
    rdchk(uidma_pkg::ADDR_FIFO, 8'hc1, "thr_refill");
    check("thr_refill_irq", CHANNEL_IRQ_OUT_O, 8'h00);
    access(1'b1, uidma_pkg::ADDR_MASK, 8'h00);
    // Polled mode: all sources masked, random status and levels
    for (int i = 0; i < 8; i++)
    begin
      v = $random(seed);
      BUS_MODE_I = uidma_pkg::uidma_bus_mode_t'(v[20]);
      fifo_control_reg(v[1:0], v[2]);
      misc = v[15:8];
      mv(v[17:16], v[19:18]);
      rdchk(uidma_pkg::ADDR_LINE_STAT, lsr_exp(1'b1), "status");
      check("polled_irq", {CHANNEL_IRQ_OUT_O, SHARED_IRQ_OE_O}, 8'h00);
    end
    report_and_stop();
  end

  initial
  begin
    #200000;
    mismatches++;
    report_and_stop();
  end
endmodule : testbench
